// [hw/sdbst_cfg.svh]
// timing figures and derived cycle counts for the bank state tracker
// assumes a single 10 MHz device clock shared with the command source
`ifndef SDBST_CFG_SVH
`define SDBST_CFG_SVH

`define SDBST_CLOCK_PERIOD_NS       100
`define SDBST_NUM_BANKS             8
`define SDBST_BANK_ADDR_W           3
`define SDBST_TIMER_W               16

// least times in ns; plain defaults, tune per speed grade
`define SDBST_PER_BANK_REFRESH_NS   90
`define SDBST_ALL_BANK_REFRESH_NS   130
`define SDBST_MODE_READ_BUSY_NS     200
`define SDBST_MODE_WRITE_BUSY_NS    500
`define SDBST_PRECHARGE_NS          18
`define SDBST_ROW_TO_COLUMN_NS      18
`define SDBST_BURST_NS              400
`define SDBST_INIT_NS               200000

// least time -> whole cycles, rounded up
`define SDBST_CYC(ns) (((ns) + `SDBST_CLOCK_PERIOD_NS - 1) / `SDBST_CLOCK_PERIOD_NS)

`define SDBST_PER_BANK_REFRESH_CYC  `SDBST_CYC(`SDBST_PER_BANK_REFRESH_NS)
`define SDBST_ALL_BANK_REFRESH_CYC  `SDBST_CYC(`SDBST_ALL_BANK_REFRESH_NS)
`define SDBST_MODE_READ_BUSY_CYC    `SDBST_CYC(`SDBST_MODE_READ_BUSY_NS)
`define SDBST_MODE_WRITE_BUSY_CYC   `SDBST_CYC(`SDBST_MODE_WRITE_BUSY_NS)
`define SDBST_PRECHARGE_CYC         `SDBST_CYC(`SDBST_PRECHARGE_NS)
`define SDBST_ROW_TO_COLUMN_CYC     `SDBST_CYC(`SDBST_ROW_TO_COLUMN_NS)
`define SDBST_BURST_CYC             `SDBST_CYC(`SDBST_BURST_NS)
`define SDBST_INIT_CYC              `SDBST_CYC(`SDBST_INIT_NS)

`endif

// [hw/sdbst_pkg.sv]
// types shared by the bank state tracker modules
// assumes nothing beyond a SystemVerilog compiler
package sdbst_pkg;

    typedef enum logic [3:0] {
        CMD_NO_OPERATION,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH_PER_BANK,
        CMD_REFRESH_ALL_BANK,
        CMD_MODE_REGISTER_READ,
        CMD_MODE_REGISTER_WRITE,
        CMD_BURST_TERMINATE
    } sdbst_cmd_t;

    typedef enum logic [3:0] {
        BK_IDLE,
        BK_ACTIVATING,
        BK_ACTIVE,
        BK_READING,
        BK_WRITING,
        BK_READ_AUTO_PRE,
        BK_WRITE_AUTO_PRE,
        BK_PRECHARGING,
        BK_REFRESHING,
        BK_MODE_READING
    } sdbst_bank_t;

    typedef enum logic [3:0] {
        DV_POWER_ON,
        DV_RESETTING,
        DV_RESET_MODE_READ,
        DV_IDLE,
        DV_IDLE_MODE_READ,
        DV_MODE_WRITING,
        DV_REFRESH_ALL,
        DV_PRECHARGE_ALL
    } sdbst_dev_t;

endpackage

// [hw/sdbst_bank.sv]
// one bank: state and down-counting busy timer
// assumes strobes already qualified by bank address and device state
`include "sdbst_cfg.svh"

module sdbst_bank #(
    parameter int unsigned TW    = `SDBST_TIMER_W,
    parameter int unsigned RCD   = `SDBST_ROW_TO_COLUMN_CYC,
    parameter int unsigned RP    = `SDBST_PRECHARGE_CYC,
    parameter int unsigned RFCPB = `SDBST_PER_BANK_REFRESH_CYC,
    parameter int unsigned MRRT  = `SDBST_MODE_READ_BUSY_CYC,
    parameter int unsigned BURST = `SDBST_BURST_CYC
) (
    input  wire logic          clock,      // device clock
    input  wire logic          rst,        // async reset, high
    input  wire logic          act,        // activate to this bank
    input  wire logic          refresh,    // per-bank refresh
    input  wire logic          precharge,  // single or all-bank precharge
    input  wire logic          readCmd,    // read to this bank
    input  wire logic          writeCmd,   // write to this bank
    input  wire logic          autoPre,    // access closes the row
    input  wire logic          modeRead,   // mode register read seen
    input  wire logic          burstStop,  // terminate aimed here
    output sdbst_pkg::sdbst_bank_t state   // current bank state
);
    import sdbst_pkg::*;

    sdbst_bank_t   state_r;
    sdbst_bank_t   stateNxt;
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cntNxt;

    wire timeUp  = (cnt_r == TW'(1));
    wire inBurst = (state_r == BK_READING) || (state_r == BK_WRITING);
    wire isOpen  = inBurst || (state_r == BK_ACTIVE);

    assign state = state_r;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        stateNxt = state_r;
        cntNxt   = (cnt_r != '0) ? cnt_r - TW'(1) : cnt_r;
        case (state_r)
            BK_IDLE: begin
                if (act) begin
                    stateNxt = BK_ACTIVATING;
                    cntNxt   = TW'(RCD);
                end else if (refresh) begin
                    stateNxt = BK_REFRESHING;
                    cntNxt   = TW'(RFCPB);
                end else if (precharge) begin
                    // idle bank still blocked for the full time
                    stateNxt = BK_PRECHARGING;
                    cntNxt   = TW'(RP);
                end
            end
            BK_ACTIVATING, BK_MODE_READING: begin
                if (timeUp) stateNxt = BK_ACTIVE;
            end
            BK_PRECHARGING, BK_REFRESHING,
            BK_READ_AUTO_PRE, BK_WRITE_AUTO_PRE: begin
                if (timeUp) stateNxt = BK_IDLE;
            end
            default: begin
                if (precharge) begin
                    stateNxt = BK_PRECHARGING;
                    cntNxt   = TW'(RP);
                end else if (readCmd) begin
                    stateNxt = autoPre ? BK_READ_AUTO_PRE : BK_READING;
                    cntNxt   = autoPre ? TW'(RP) : TW'(BURST);
                end else if (writeCmd) begin
                    stateNxt = autoPre ? BK_WRITE_AUTO_PRE : BK_WRITING;
                    cntNxt   = autoPre ? TW'(RP) : TW'(BURST);
                end else if (modeRead && state_r == BK_ACTIVE) begin
                    stateNxt = BK_MODE_READING;
                    cntNxt   = TW'(MRRT);
                end else if (inBurst && (burstStop || timeUp)) begin
                    stateNxt = BK_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= BK_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= stateNxt;
            cnt_r   <= cntNxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_refresh_ends: assert property (@(posedge clock) disable iff (rst)
        state_r == BK_REFRESHING && timeUp |=> state_r == BK_IDLE)
        else $error("bank refresh did not return to idle");

    a_activate_delay: assert property (@(posedge clock) disable iff (rst)
        state_r == BK_IDLE && act |=>
            state_r == BK_ACTIVATING && cnt_r == TW'(RCD))
        else $error("activate did not start row delay");

    a_idle_precharge: assert property (@(posedge clock) disable iff (rst)
        state_r == BK_IDLE && precharge && !act && !refresh |=>
            state_r == BK_PRECHARGING && cnt_r == TW'(RP))
        else $error("precharge of idle bank not timed");

    a_mode_read_bank: assert property (@(posedge clock) disable iff (rst)
        state_r == BK_MODE_READING && timeUp |=> state_r == BK_ACTIVE)
        else $error("bank mode read did not return to active");

    a_stop_to_active: assert property (@(posedge clock) disable iff (rst)
        inBurst && burstStop && !precharge && !readCmd && !writeCmd |=>
            state_r == BK_ACTIVE)
        else $error("burst terminate did not leave bank active");

    a_open_access: assert property (@(posedge clock) disable iff (rst)
        isOpen && readCmd && !precharge && !autoPre |=>
            state_r == BK_READING && cnt_r == TW'(BURST))
        else $error("read did not start a burst");

endmodule

// [hw/sdbst_tracker.sv]
// Behaviour
// - per-bank refresh busy, then bank idle
// - all-bank refresh busy, then all idle
// - idle or resetting mode read, then idle
// - active-bank mode read busy, then active
// - mode write busy, then all banks idle
// - precharge-all busy, then banks idle, except banks activating or mode reading (these end active)
// - single precharge busy, then bank idle
// - activate waits row delay before active
// - reset is mode write; enters resetting
// - terminate hits most recent burst's bank
// - terminate leaves that bank active, unless its burst auto-precharges (that bank still goes idle)
// - precharge of idle bank still timed
// - other-bank accesses accepted during bursts
// - power-on reset starts init; mode read
//
// top of the bank and device state tracker
// assumes commands are decoded and on the device clock, one per edge
`include "sdbst_cfg.svh"

module sdbst_tracker #(
    parameter int unsigned NB     = `SDBST_NUM_BANKS,
    parameter int unsigned BW     = `SDBST_BANK_ADDR_W,
    parameter int unsigned TW     = `SDBST_TIMER_W,
    parameter int unsigned RFCAB  = `SDBST_ALL_BANK_REFRESH_CYC,
    parameter int unsigned MRRT   = `SDBST_MODE_READ_BUSY_CYC,
    parameter int unsigned MRWT   = `SDBST_MODE_WRITE_BUSY_CYC,
    parameter int unsigned RP     = `SDBST_PRECHARGE_CYC,
    parameter int unsigned INIT   = `SDBST_INIT_CYC
) (
    input  wire logic                 clock,            // 10 MHz clock
    input  wire logic                 rst,              // async, high
    input  sdbst_pkg::sdbst_cmd_t     cmdCode,          // command this edge
    input  wire logic [BW-1:0]        cmdBank,          // target bank
    input  wire logic                 cmdAllBanks,      // precharge all
    input  wire logic                 cmdAutoPrecharge, // access closes row
    input  wire logic                 cmdReset,         // mode write = reset
    output sdbst_pkg::sdbst_bank_t    bankState [NB],   // per-bank state
    output sdbst_pkg::sdbst_dev_t     devState,         // device state
    output logic                      allIdle,          // banks and device idle, lagged
    output logic                      burstOn,          // burst in progress
    output logic [BW-1:0]             burstBank         // bank of last burst
);
    import sdbst_pkg::*;

    sdbst_dev_t    dev_r;
    sdbst_dev_t    devNxt;
    logic [TW-1:0] dcnt_r;
    logic [TW-1:0] dcntNxt;
    logic          allIdle_r;
    logic          burstOn_r;
    logic          burstOnNxt;
    logic [BW-1:0] burstBank_r;
    logic [BW-1:0] burstBankNxt;
    logic [NB-1:0] bankIdle;
    logic [NB-1:0] bankOpen;
    logic [NB-1:0] bankInBurst;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    wire devReady   = (dev_r == DV_IDLE);
    wire cmdAct     = (cmdCode == CMD_ACTIVATE);
    wire cmdRead    = (cmdCode == CMD_READ);
    wire cmdWrite   = (cmdCode == CMD_WRITE);
    wire cmdPre     = (cmdCode == CMD_PRECHARGE);
    wire cmdRefPb   = (cmdCode == CMD_REFRESH_PER_BANK);
    wire cmdRefAb   = (cmdCode == CMD_REFRESH_ALL_BANK);
    wire cmdModeRd  = (cmdCode == CMD_MODE_REGISTER_READ);
    wire cmdModeWr  = (cmdCode == CMD_MODE_REGISTER_WRITE);
    wire cmdStop    = (cmdCode == CMD_BURST_TERMINATE);
    wire banksIdle  = &bankIdle;
    wire devTimeUp  = (dcnt_r == TW'(1));
    wire tgtOpen    = bankOpen[cmdBank];
    // an access opens a burst only where the bank can take it
    wire accessTake = devReady && (cmdRead || cmdWrite) && tgtOpen;
    wire curInBurst = bankInBurst[burstBank_r];
    // the terminate follows the last burst, not the addressed bank
    wire stopTake   = cmdStop && burstOn_r;

    ////////////////////////////////////////////////////////////////////////
    // banks
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : gBank
            wire hit = (cmdBank == BW'(g));
            assign bankIdle[g]    = (bankState[g] == BK_IDLE);
            assign bankOpen[g]    = (bankState[g] == BK_ACTIVE) ||
                                    (bankState[g] == BK_READING) ||
                                    (bankState[g] == BK_WRITING);
            assign bankInBurst[g] = (bankState[g] == BK_READING) ||
                                    (bankState[g] == BK_WRITING) ||
                                    (bankState[g] == BK_READ_AUTO_PRE) ||
                                    (bankState[g] == BK_WRITE_AUTO_PRE);
            sdbst_bank #(
                .TW    (TW),
                .RP    (RP),
                .MRRT  (MRRT)
            ) uBank (
                .clock     (clock),
                .rst       (rst),
                .act       (devReady && cmdAct && hit),
                .refresh   (devReady && cmdRefPb && hit),
                .precharge (devReady && cmdPre && (hit || cmdAllBanks)),
                .readCmd   (devReady && cmdRead && hit),
                .writeCmd  (devReady && cmdWrite && hit),
                .autoPre   (cmdAutoPrecharge),
                .modeRead  (devReady && cmdModeRd),
                .burstStop (stopTake && burstBank_r == BW'(g)),
                .state     (bankState[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // device-wide state
    always_comb begin
        devNxt  = dev_r;
        dcntNxt = (dcnt_r != '0) ? dcnt_r - TW'(1) : dcnt_r;
        case (dev_r)
            DV_POWER_ON: begin
                if (cmdModeWr && cmdReset) begin
                    devNxt  = DV_RESETTING;
                    dcntNxt = TW'(INIT);
                end
            end
            DV_RESETTING: begin
                if (cmdModeWr && cmdReset) begin
                    devNxt  = DV_RESETTING;
                    dcntNxt = TW'(INIT);
                end else if (cmdModeRd) begin
                    devNxt  = DV_RESET_MODE_READ;
                    dcntNxt = TW'(MRRT);
                end else if (devTimeUp) begin
                    devNxt  = DV_IDLE;
                end
            end
            DV_IDLE: begin
                if (cmdRefAb && banksIdle) begin
                    devNxt  = DV_REFRESH_ALL;
                    dcntNxt = TW'(RFCAB);
                end else if (cmdModeWr && banksIdle && cmdReset) begin
                    devNxt  = DV_RESETTING;
                    dcntNxt = TW'(INIT);
                end else if (cmdModeWr && banksIdle) begin
                    devNxt  = DV_MODE_WRITING;
                    dcntNxt = TW'(MRWT);
                end else if (cmdModeRd && banksIdle) begin
                    devNxt  = DV_IDLE_MODE_READ;
                    dcntNxt = TW'(MRRT);
                end else if (cmdPre && cmdAllBanks) begin
                    devNxt  = DV_PRECHARGE_ALL;
                    dcntNxt = TW'(RP);
                end
            end
            default: begin
                // every timed device state here ends in device idle
                if (devTimeUp) devNxt = DV_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // most recent burst owner
    always_comb begin
        burstBankNxt = burstBank_r;
        burstOnNxt   = burstOn_r;
        if (accessTake) begin
            burstBankNxt = cmdBank;
            burstOnNxt   = 1'b1;
        end else if (stopTake || (burstOn_r && !curInBurst)) begin
            burstOnNxt   = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dev_r       <= DV_POWER_ON;
            dcnt_r      <= '0;
            allIdle_r   <= 1'b1;
            burstOn_r   <= 1'b0;
            burstBank_r <= '0;
        end else begin
            dev_r       <= devNxt;
            dcnt_r      <= dcntNxt;
            allIdle_r   <= banksIdle && (dev_r == DV_IDLE);
            burstOn_r   <= burstOnNxt;
            burstBank_r <= burstBankNxt;
        end
    end

    assign devState  = dev_r;
    assign allIdle   = allIdle_r;
    assign burstOn   = burstOn_r;
    assign burstBank = burstBank_r;

    ////////////////////////////////////////////////////////////////////////
    a_all_refresh: assert property (@(posedge clock) disable iff (rst)
        devReady && cmdRefAb && banksIdle |=>
            dev_r == DV_REFRESH_ALL && dcnt_r == TW'(RFCAB))
        else $error("all-bank refresh not entered with full time");

    a_all_refresh_end: assert property (@(posedge clock) disable iff (rst)
        dev_r == DV_REFRESH_ALL && devTimeUp |=> dev_r == DV_IDLE)
        else $error("all-bank refresh did not end in idle");

    a_reset_entry: assert property (@(posedge clock) disable iff (rst)
        dev_r == DV_POWER_ON && cmdModeWr && cmdReset |=>
            dev_r == DV_RESETTING && dcnt_r == TW'(INIT))
        else $error("reset did not start initialization");

    a_reset_mode_read: assert property (@(posedge clock) disable iff (rst)
        dev_r == DV_RESETTING && cmdModeRd && !cmdModeWr |=>
            dev_r == DV_RESET_MODE_READ ##(MRRT) dev_r == DV_IDLE)
        else $error("resetting mode read not timed");

    a_mode_write: assert property (@(posedge clock) disable iff (rst)
        devReady && banksIdle && cmdModeWr && !cmdReset && !cmdRefAb |=>
            dev_r == DV_MODE_WRITING ##(MRWT) dev_r == DV_IDLE)
        else $error("mode write busy time wrong");

    a_precharge_all: assert property (@(posedge clock) disable iff (rst)
        dev_r == DV_PRECHARGE_ALL && devTimeUp |=>
            dev_r == DV_IDLE && $past(dcnt_r) == TW'(1))
        else $error("precharge-all did not end in idle");

    a_idle_mode_read: assert property (@(posedge clock) disable iff (rst)
        dev_r == DV_IDLE_MODE_READ && devTimeUp |=> dev_r == DV_IDLE)
        else $error("idle mode read did not end in idle");

    a_burst_owner: assert property (@(posedge clock) disable iff (rst)
        accessTake |=> burstOn_r && burstBank_r == $past(cmdBank))
        else $error("burst owner not tracked");

    a_stop_clears: assert property (@(posedge clock) disable iff (rst)
        stopTake && !accessTake |=> !burstOn_r)
        else $error("terminate did not clear burst");

endmodule

// [verification/sdbst_ctrl_model.sv]
// command source standing in for the memory controller
// assumes nothing of the bench, which also asks for commands illegal in the current state
module sdbst_ctrl_model (
    input  wire logic             clock,            // device clock
    input  wire logic             rst,              // async reset, high
    input  wire logic             reqValid,         // bench wants a command
    input  sdbst_pkg::sdbst_cmd_t reqCode,          // requested command
    input  wire logic [2:0]       reqBank,          // requested bank
    input  wire logic             reqAll,           // precharge all banks
    input  wire logic             reqAp,            // access closes the row
    input  wire logic             reqReset,         // mode write is reset
    output sdbst_pkg::sdbst_cmd_t cmdCode,          // command to tracker
    output logic [2:0]            cmdBank,          // bank to tracker
    output logic                  cmdAllBanks,      // all-bank qualifier
    output logic                  cmdAutoPrecharge, // auto close qualifier
    output logic                  cmdReset          // reset qualifier
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdbst_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] noise_r;

    // idle qualifiers wander so stale values cannot hide a decode slip
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            noise_r <= 4'h5;
        end else begin
            noise_r <= noise_r + 4'h7;
        end
    end

    // no request means a no-op on every edge, busy states included
    assign cmdCode          = reqValid ? reqCode : CMD_NO_OPERATION;
    assign cmdBank          = reqValid ? reqBank : noise_r[2:0];
    assign cmdAllBanks      = reqValid ? reqAll : noise_r[3];
    assign cmdAutoPrecharge = reqValid ? reqAp : noise_r[1];
    assign cmdReset         = reqValid ? reqReset : noise_r[0];
endmodule

// [verification/tb.sv]
// self-checking bench for the bank and device state tracker
// assumes tracker, package and command source model are compiled first
`include "sdbst_cfg.svh"
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin badCount++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdbst_pkg::*;

    // init shortened so a reset finishes in a few cycles
    localparam int unsigned INITC = 10;
    localparam int unsigned RFPB  = `SDBST_PER_BANK_REFRESH_CYC;
    localparam int unsigned RFAB  = `SDBST_ALL_BANK_REFRESH_CYC;
    localparam int unsigned MRRC  = `SDBST_MODE_READ_BUSY_CYC;
    localparam int unsigned MRWC  = `SDBST_MODE_WRITE_BUSY_CYC;
    localparam int unsigned RPC   = `SDBST_PRECHARGE_CYC;
    localparam int unsigned RCDC  = `SDBST_ROW_TO_COLUMN_CYC;
    localparam int unsigned BSTC  = `SDBST_BURST_CYC;

    logic        clock;
    logic        rst;
    logic        reqValid;
    sdbst_cmd_t  reqCode;
    logic [2:0]  reqBank;
    logic        reqAll;
    logic        reqAp;
    logic        reqReset;
    sdbst_cmd_t  cmdCode;
    logic [2:0]  cmdBank;
    logic        cmdAllBanks;
    logic        cmdAutoPrecharge;
    logic        cmdReset;
    sdbst_bank_t bankState [8];
    sdbst_dev_t  devState;
    logic        allIdle;
    logic        burstOn;
    logic [2:0]  burstBank;
    logic [31:0] seed;
    logic [2:0]  b;
    logic [2:0]  m;
    logic        wr;
    logic        ap;
    int          badCount = 0;
    int          testsRun = 0;
    int          cycles = 0;

    sdbst_ctrl_model sdbst_ctrl_model_i (.clock(clock), .rst(rst),
        .reqValid(reqValid), .reqCode(reqCode), .reqBank(reqBank),
        .reqAll(reqAll), .reqAp(reqAp), .reqReset(reqReset),
        .cmdCode(cmdCode), .cmdBank(cmdBank), .cmdAllBanks(cmdAllBanks),
        .cmdAutoPrecharge(cmdAutoPrecharge), .cmdReset(cmdReset));

    sdbst_tracker #(.INIT(INITC)) sdbst_tracker_i (.clock(clock),
        .rst(rst), .cmdCode(cmdCode), .cmdBank(cmdBank),
        .cmdAllBanks(cmdAllBanks), .cmdAutoPrecharge(cmdAutoPrecharge),
        .cmdReset(cmdReset), .bankState(bankState), .devState(devState),
        .allIdle(allIdle), .burstOn(burstOn), .burstBank(burstBank));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic sdbst_bank_t accessState(input logic w, input logic a);
        if (a) begin
            return w ? BK_WRITE_AUTO_PRE : BK_READ_AUTO_PRE;
        end
        return w ? BK_WRITING : BK_READING;
    endfunction

    task automatic results;
        $display("comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one command for one edge; returns just after the edge that took it
    task automatic issue(input sdbst_cmd_t c, input logic [2:0] bk,
                         input logic a, input logic p, input logic r);
        @(posedge clock);
        reqValid <= 1'b1;
        reqCode  <= c;
        reqBank  <= bk;
        reqAll   <= a;
        reqAp    <= p;
        reqReset <= r;
        @(posedge clock);
        reqValid <= 1'b0;
        #1;
    endtask

    task automatic seeBank(input logic [2:0] bk, input sdbst_bank_t s,
                           input int n);
        repeat (n) begin
            `CHK(bankState[bk], s)
            @(posedge clock);
            #1;
        end
    endtask

    task automatic seeDev(input sdbst_dev_t s, input int n);
        repeat (n) begin
            `CHK(devState, s)
            @(posedge clock);
            #1;
        end
    endtask

    // a hang costs one mismatch and still reaches the report
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            badCount++;
            results;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqCode = CMD_NO_OPERATION;
        reqBank = 3'h0;
        reqAll = 1'b0;
        reqAp = 1'b0;
        reqReset = 1'b0;
        seed = 32'h00017337;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHK(burstOn, 1'b0)
        issue(CMD_ACTIVATE, 3'h0, 1'b0, 1'b0, 1'b0);
        seeBank(3'h0, BK_IDLE, 1);
        `CHK(devState, DV_POWER_ON)
        issue(CMD_MODE_REGISTER_WRITE, 3'h0, 1'b0, 1'b0, 1'b1);
        seeDev(DV_RESETTING, INITC);
        `CHK(devState, DV_IDLE)
        issue(CMD_MODE_REGISTER_WRITE, 3'h0, 1'b0, 1'b0, 1'b1);
        seeDev(DV_RESETTING, 1);
        issue(CMD_MODE_REGISTER_READ, 3'h0, 1'b0, 1'b0, 1'b0);
        seeDev(DV_RESET_MODE_READ, MRRC);
        `CHK(devState, DV_IDLE)
        issue(CMD_MODE_REGISTER_READ, 3'h0, 1'b0, 1'b0, 1'b0);
        seeDev(DV_IDLE_MODE_READ, MRRC);
        `CHK(devState, DV_IDLE)
        issue(CMD_MODE_REGISTER_WRITE, 3'h0, 1'b0, 1'b0, 1'b0);
        seeDev(DV_MODE_WRITING, MRWC);
        `CHK(devState, DV_IDLE)
        issue(CMD_REFRESH_ALL_BANK, 3'h0, 1'b0, 1'b0, 1'b0);
        seeDev(DV_REFRESH_ALL, RFAB);
        `CHK(devState, DV_IDLE)
        for (int i = 0; i < 12; i++) begin
            seed = xorshift(seed);
            b = seed[2:0];
            m = ~seed[2:0];
            // first four passes walk every access kind before chance
            wr = (i < 4) ? i[1] : seed[8];
            ap = (i < 4) ? i[0] : seed[9];
            issue(CMD_REFRESH_PER_BANK, b, 1'b0, 1'b0, 1'b0);
            seeBank(b, BK_REFRESHING, RFPB);
            `CHK(bankState[b], BK_IDLE)
            issue(CMD_PRECHARGE, b, 1'b0, 1'b0, 1'b0);
            seeBank(b, BK_PRECHARGING, RPC);
            `CHK(bankState[b], BK_IDLE)
            issue(CMD_ACTIVATE, b, 1'b0, 1'b0, 1'b0);
            seeBank(b, BK_ACTIVATING, RCDC);
            `CHK(bankState[b], BK_ACTIVE)
            `CHK(allIdle, 1'b0)
            issue(CMD_ACTIVATE, m, 1'b0, 1'b0, 1'b0);
            issue(wr ? CMD_WRITE : CMD_READ, b, 1'b0, 1'b0, 1'b0);
            `CHK(bankState[b], accessState(wr, 1'b0))
            `CHK(burstBank, b)
            issue(wr ? CMD_WRITE : CMD_READ, m, 1'b0, ap, 1'b0);
            `CHK(bankState[m], accessState(wr, ap))
            `CHK(burstBank, m)
            `CHK(burstOn, 1'b1)
            if (ap) begin
                seeBank(m, accessState(wr, 1'b1), 1);
                `CHK(bankState[m], BK_IDLE)
            end else begin
                issue(CMD_BURST_TERMINATE, b, 1'b0, 1'b0, 1'b0);
                `CHK(bankState[m], BK_ACTIVE)
                `CHK(burstOn, 1'b0)
            end
            repeat (BSTC) @(posedge clock);
            #1;
            `CHK(bankState[b], BK_ACTIVE)
            issue(CMD_REFRESH_PER_BANK, b, 1'b0, 1'b0, 1'b0);
            `CHK(bankState[b], BK_ACTIVE)
            issue(CMD_MODE_REGISTER_READ, b, 1'b0, 1'b0, 1'b0);
            seeBank(b, BK_MODE_READING, MRRC);
            `CHK(bankState[b], BK_ACTIVE)
            issue(CMD_PRECHARGE, b, 1'b1, 1'b0, 1'b0);
            `CHK(bankState[b], BK_PRECHARGING)
            seeDev(DV_PRECHARGE_ALL, RPC);
            `CHK(devState, DV_IDLE)
            `CHK(bankState[m], BK_IDLE)
        end
        repeat (2) @(posedge clock);
        #1;
        `CHK(allIdle, 1'b1)
        `CHK(burstOn, 1'b0)
        results;
    end
endmodule
